// >>> hdl/rld_pkg.sv
// Purpose: shared constants for the radio link diagnostics block
// Assumes: 100 MHz system clock, command codes double as register offsets
// Notes: identity words are arbitrary neutral values
package rld_pkg;
  // command codes, also the register offsets
  localparam logic [7:0] CODE_RX_ABORT = 8'h0f;
  localparam logic [7:0] CODE_FACTORY_LOAD = 8'h0e;
  localparam logic [7:0] CODE_FW_VERSION = 8'h14;
  localparam logic [7:0] CODE_TX_DROP = 8'h1b;
  localparam logic [7:0] CODE_LAST_LEVEL = 8'h1c;
  localparam logic [7:0] CODE_PWM_HOLD = 8'h22;
  localparam logic [7:0] CODE_SERIAL_UPPER = 8'h25;
  localparam logic [7:0] CODE_SERIAL_LOWER = 8'h26;
  localparam logic [7:0] CODE_IN_BUF_SIZE = 8'h2c;
  localparam logic [7:0] CODE_INTEGRITY = 8'h40;

  // reset and factory values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [7:0] HOLD_FOREVER = 8'hff;
  localparam logic [7:0] LEVEL_MIN = 8'h06;
  localparam logic [7:0] LEVEL_MAX = 8'h36;

  // identity and size words, values arbitrary
  localparam logic [15:0] FW_VERSION = 16'h1000;
  localparam logic [15:0] SERIAL_UPPER = 16'h0000;
  localparam logic [15:0] SERIAL_LOWER = 16'h0001;
  localparam logic [7:0] IN_BUF_SIZE = 8'h80;
  localparam logic [8:0] OUT_BUF_SIZE = 9'({1'b0, IN_BUF_SIZE} + {2'b00, IN_BUF_SIZE[7:1]});

  // pwm shape: 40 steps of 0.208 ms make 8.32 ms
  localparam int CLK_PERIOD_NS = 10;
  localparam int PWM_STEP_NS = 208000;
  localparam int PWM_STEP_CYCLES = PWM_STEP_NS / CLK_PERIOD_NS;
  localparam logic [5:0] PWM_STEPS = 6'h28;
  localparam logic [5:0] DUTY_MAX = 6'h26;
  localparam logic [5:0] DUTY_BASE = 6'h0d;
  localparam logic [3:0] DUTY_MUL = 4'h6;
  localparam logic [3:0] DUTY_DIV = 4'ha;

  // hold time unit 100 ms
  localparam int HOLD_UNIT_NS = 100000000;
  localparam int HOLD_UNIT_CYCLES = HOLD_UNIT_NS / CLK_PERIOD_NS;

  // strap settle wait after reset release
  localparam logic [2:0] STRAP_WAIT = 3'h4;
endpackage

// >>> hdl/rld_diag.sv
// Purpose: diagnostic counters, identity words and signal strength pwm of a radio module
// Assumes: events and commands come from logic on clk_in; the strap pin is asynchronous
// Notes: counters are volatile and clear on reset; nothing here is saved
`timescale 1ns/1ns
`default_nettype none
module rld_diag #(
  parameter int STEP_CYCLES = rld_pkg::PWM_STEP_CYCLES,
  parameter int UNIT_CYCLES = rld_pkg::HOLD_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // parameter command port
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_param_in,
  output logic rsp_valid_out,
  output logic rsp_error_out,
  output logic [15:0] rsp_data_out,
  output logic factory_default_out,
  // radio events, one-cycle pulses
  input wire logic rx_abort_event_in,
  input wire logic integrity_event_in,
  input wire logic tx_drop_event_in,
  input wire logic packet_rx_in,
  input wire logic [7:0] packet_level_in,
  // shared strap and pwm pin
  input wire logic config_pin_in,
  output logic config_pin_out,
  output logic config_pin_oe_n_out,
  output logic command_mode_out,
  output logic strap_valid_out,
  output logic [8:0] out_buffer_size_out
);
  typedef enum logic [1:0] {RLD_STARTUP, RLD_RUN} rld_state_t;

  logic [15:0] count_q [3];
  logic [2:0] cnt_event;
  logic [2:0] cnt_load;
  logic [7:0] cnt_code [3];
  logic [7:0] hold_q;
  logic [7:0] level_q;
  logic [15:0] rsp_d;
  logic err_d;
  logic cmd_wr;
  logic factory_hit;
  logic hold_hit;

  // command decode
  assign cmd_wr = cmd_valid_in & cmd_write_in;
  assign factory_hit = cmd_valid_in & (cmd_code_in == rld_pkg::CODE_FACTORY_LOAD);
  assign hold_hit = cmd_wr & (cmd_code_in == rld_pkg::CODE_PWM_HOLD);
  assign cnt_code[0] = rld_pkg::CODE_RX_ABORT;
  assign cnt_code[1] = rld_pkg::CODE_INTEGRITY;
  assign cnt_code[2] = rld_pkg::CODE_TX_DROP;
  assign cnt_event = {tx_drop_event_in, integrity_event_in, rx_abort_event_in};
  assign out_buffer_size_out = rld_pkg::OUT_BUF_SIZE;

  // three saturating event counters; a load beats an event in the same cycle
  // saturation is tested before the add, so a busy counter never wraps back to zero
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cnt
      assign cnt_load[gi] = cmd_wr & (cmd_code_in == cnt_code[gi]);
      always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          count_q[gi] <= rld_pkg::COUNT_RESET;
        end else if (cnt_load[gi]) begin
          count_q[gi] <= cmd_param_in;
        end else if (cnt_event[gi] && count_q[gi] != rld_pkg::COUNT_MAX) begin
          count_q[gi] <= count_q[gi] + 16'h0001;
        end
      end
    end
  endgenerate

  // hold setting; factory load restores it but nothing is saved
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hold_q <= rld_pkg::HOLD_RESET;
    end else if (factory_hit) begin
      hold_q <= rld_pkg::HOLD_RESET;
    end else if (hold_hit) begin
      hold_q <= cmd_param_in[7:0];
    end
  end

  // last packet strength, clamped into the reported span
  // before any packet a query reads the floor, never a stale strength
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      level_q <= rld_pkg::LEVEL_MIN;
    end else if (packet_rx_in) begin
      if (packet_level_in < rld_pkg::LEVEL_MIN) begin
        level_q <= rld_pkg::LEVEL_MIN;
      end else if (packet_level_in > rld_pkg::LEVEL_MAX) begin
        level_q <= rld_pkg::LEVEL_MAX;
      end else begin
        level_q <= packet_level_in;
      end
    end
  end

  // read mux; writes to read-only words and unknown codes answer with error
  // a load answers with the old value, so one command both reads and resets a count
  always_comb begin
    rsp_d = 16'h0000;
    err_d = 1'b0;
    case (cmd_code_in)
      rld_pkg::CODE_RX_ABORT: rsp_d = count_q[0];
      rld_pkg::CODE_INTEGRITY: rsp_d = count_q[1];
      rld_pkg::CODE_TX_DROP: rsp_d = count_q[2];
      rld_pkg::CODE_PWM_HOLD: rsp_d = {8'h00, hold_q};
      rld_pkg::CODE_FACTORY_LOAD: rsp_d = 16'h0000;
      rld_pkg::CODE_LAST_LEVEL: begin
        rsp_d = {8'h00, level_q};
        err_d = cmd_write_in;
      end
      rld_pkg::CODE_IN_BUF_SIZE: begin
        rsp_d = {8'h00, rld_pkg::IN_BUF_SIZE};
        err_d = cmd_write_in;
      end
      rld_pkg::CODE_SERIAL_UPPER: begin
        rsp_d = rld_pkg::SERIAL_UPPER;
        err_d = cmd_write_in;
      end
      rld_pkg::CODE_SERIAL_LOWER: begin
        rsp_d = rld_pkg::SERIAL_LOWER;
        err_d = cmd_write_in;
      end
      rld_pkg::CODE_FW_VERSION: begin
        rsp_d = rld_pkg::FW_VERSION;
        err_d = cmd_write_in;
      end
      default: err_d = 1'b1;
    endcase
  end

  // answer registers, one cycle after the command
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rsp_valid_out <= 1'b0;
      rsp_error_out <= 1'b0;
      rsp_data_out <= 16'h0000;
      factory_default_out <= 1'b0;
    end else begin
      rsp_valid_out <= cmd_valid_in;
      rsp_error_out <= cmd_valid_in & err_d;
      rsp_data_out <= cmd_valid_in ? rsp_d : 16'h0000;
      factory_default_out <= factory_hit;
    end
  end

  // strap synchroniser; only the second and third stages are compared
  // stages reset to the released level so reset itself never looks like a low strap
  logic strap_s1_q, strap_s2_q, strap_s3_q;
  logic [2:0] settle_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      strap_s1_q <= 1'b1;
      strap_s2_q <= 1'b1;
      strap_s3_q <= 1'b1;
    end else begin
      strap_s1_q <= config_pin_in;
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
    end
  end

  // catch the strap once after release; a low pin asks for command mode
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      settle_q <= 3'h0;
      strap_valid_out <= 1'b0;
      command_mode_out <= 1'b0;
    end else if (!strap_valid_out) begin
      if (settle_q != rld_pkg::STRAP_WAIT) begin
        settle_q <= settle_q + 3'h1;
      end else if (strap_s2_q == strap_s3_q) begin
        strap_valid_out <= 1'b1;
        command_mode_out <= ~strap_s3_q;
      end
    end
  end

  // step divider and 40-step frame counter
  logic [14:0] step_cnt_q;
  logic [5:0] step_idx_q;
  logic step_tick;
  logic frame_last;
  assign step_tick = (step_cnt_q == 15'(STEP_CYCLES - 1));
  assign frame_last = (step_idx_q == rld_pkg::PWM_STEPS - 6'h01);
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      step_cnt_q <= 15'h0000;
      step_idx_q <= 6'h00;
    end else if (step_tick) begin
      step_cnt_q <= 15'h0000;
      step_idx_q <= frame_last ? 6'h00 : step_idx_q + 6'h01;
    end else begin
      step_cnt_q <= step_cnt_q + 15'h0001;
    end
  end

  // duty from strength: 0.6 step per dB above sensitivity, offset 13, capped at 38
  logic [7:0] db_above;
  logic [10:0] db_scaled;
  logic [10:0] duty_raw;
  logic [5:0] duty_level;
  assign db_above = level_q - rld_pkg::LEVEL_MIN;
  assign db_scaled = (11'(db_above) * 11'(rld_pkg::DUTY_MUL)) / 11'(rld_pkg::DUTY_DIV);
  assign duty_raw = db_scaled + 11'(rld_pkg::DUTY_BASE);
  assign duty_level = (db_above == 8'h00) ? 6'h00 :
                      (duty_raw > 11'(rld_pkg::DUTY_MAX)) ? rld_pkg::DUTY_MAX :
                      duty_raw[5:0];

  // hold timer: a unit divider and a count of 100 ms units
  rld_state_t state_q;
  logic [23:0] unit_cnt_q;
  logic [7:0] units_q;
  logic show_q;
  logic unit_tick;
  logic timer_done;
  assign unit_tick = (unit_cnt_q == 24'(UNIT_CYCLES - 1));
  assign timer_done = (units_q >= hold_q);
  // the unit count sticks at its top so a long quiet spell never wraps under the hold
  logic units_full;
  logic hold_forever;
  assign units_full = (units_q == 8'hff);
  assign hold_forever = (hold_q == rld_pkg::HOLD_FOREVER);
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= RLD_STARTUP;
      unit_cnt_q <= 24'h000000;
      units_q <= 8'h00;
      show_q <= 1'b0;
    end else begin
      unit_cnt_q <= (unit_tick || packet_rx_in) ? 24'h000000 : unit_cnt_q + 24'h000001;
      case (state_q)
        // hold clears on reset, so the startup wait only lasts when a hold is set by then
        RLD_STARTUP: begin
          if (strap_valid_out && timer_done) begin
            state_q <= RLD_RUN;
            units_q <= 8'h00;
          end else if (unit_tick && !units_full) begin
            units_q <= units_q + 8'h01;
          end
        end
        RLD_RUN: begin
          if (packet_rx_in) begin
            show_q <= 1'b1;
            units_q <= 8'h00;
          end else if (show_q && !hold_forever && timer_done) begin
            show_q <= 1'b0;
          end else if (unit_tick && !units_full) begin
            units_q <= units_q + 8'h01;
          end
        end
        default: state_q <= RLD_STARTUP;
      endcase
    end
  end

  // hold zero keeps the pin an input for good
  logic pwm_enabled;
  assign pwm_enabled = (hold_q != rld_pkg::HOLD_RESET);

  // pin drive: input while disabled or starting, low until a packet, then pwm
  // the pin turns output only after startup, once the strap has been read
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      config_pin_oe_n_out <= 1'b1;
      config_pin_out <= 1'b0;
    end else begin
      config_pin_oe_n_out <= !(state_q == RLD_RUN && pwm_enabled);
      config_pin_out <= show_q && (step_idx_q < duty_level);
    end
  end
endmodule
`default_nettype wire

// >>> testbench/rld_diag_chk.sv
// Purpose: port assertions for the diagnostics block
// Assumes: one clock, reset_in asynchronous active high
// Notes: attached by the bind at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module rld_diag_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // command port
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic rsp_valid_out,
  input wire logic rsp_error_out,
  input wire logic [15:0] rsp_data_out,
  input wire logic factory_default_out,
  input wire logic [8:0] out_buffer_size_out
);
  // all checks share the one clock and its reset
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_rsp_taken: assert property (cmd_valid_in |=> rsp_valid_out)
    else $error("no answer one cycle after a command");
  a_rsp_cause: assert property (rsp_valid_out |-> $past(cmd_valid_in))
    else $error("answer without a command");
  a_load_ok: assert property (cmd_valid_in && cmd_write_in && cmd_code_in == 8'h0f
    |=> !rsp_error_out)
    else $error("counter load refused");
  a_ro_refused: assert property (cmd_valid_in && cmd_write_in &&
    cmd_code_in inside {8'h14, 8'h1c, 8'h25, 8'h26, 8'h2c} |=> rsp_error_out)
    else $error("write to read-only word accepted");
  a_fw_fixed: assert property (cmd_valid_in && !cmd_write_in && cmd_code_in == 8'h14
    |=> rsp_data_out == rld_pkg::FW_VERSION)
    else $error("firmware word changed");
  a_fac_pulse: assert property (cmd_valid_in && cmd_code_in == 8'h0e
    |=> factory_default_out)
    else $error("factory load not signalled");
  a_fac_cause: assert property (factory_default_out
    |-> $past(cmd_valid_in) && $past(cmd_code_in) == 8'h0e)
    else $error("factory load without its command");
  a_level_span: assert property (cmd_valid_in && !cmd_write_in && cmd_code_in == 8'h1c
    |=> rsp_data_out inside {[16'h0006:16'h0036]})
    else $error("signal level out of range");
  a_outbuf_size: assert property (cmd_valid_in && !cmd_write_in && cmd_code_in == 8'h2c
    |=> 12'(out_buffer_size_out) * 12'h002 == 12'(rsp_data_out[7:0]) * 12'h003)
    else $error("output buffer size not 1.5 times input buffer");
endmodule
bind rld_diag rld_diag_chk u_chk (.clk_in, .reset_in, .cmd_valid_in, .cmd_write_in,
  .cmd_code_in, .rsp_valid_out, .rsp_error_out, .rsp_data_out, .factory_default_out,
  .out_buffer_size_out);
`default_nettype wire

// >>> testbench/rld_host.sv
// Purpose: host side issuing parameter commands and holding the strap
// Assumes: each command is launched just after a falling edge
// Notes: never saves anything, so factory values last only until reset
`timescale 1ns/1ns
`default_nettype none
module rld_host (
  // clock
  input wire logic clk_in,
  // command port toward the device
  output logic cmd_valid_out,
  output logic cmd_write_out,
  output logic [7:0] cmd_code_out,
  output logic [15:0] cmd_param_out,
  input wire logic rsp_valid_in,
  input wire logic rsp_error_in,
  input wire logic [15:0] rsp_data_in,
  // strap level, high keeps the device out of command mode
  output logic strap_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_code_out = 8'h00;
    cmd_param_out = 16'h0000;
    strap_out = 1'b1;
  end
  // strap level seen by the device whenever it lets the pin go
  task automatic set_strap(input logic s);
    strap_out = s;
  endtask
  // hold over the taking edge, read the answer, then scramble the idle bus
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] p,
      output logic v, output logic e, output logic [15:0] d);
    cmd_valid_out = 1'b1;
    cmd_write_out = w;
    cmd_code_out = c;
    cmd_param_out = p;
    @(negedge clk_in);
    v = rsp_valid_in;
    e = rsp_error_in;
    d = rsp_data_in;
    cmd_valid_out = 1'b0;
    cmd_write_out = ~w;
    cmd_code_out = ~c;
    cmd_param_out = ~p;
    @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the diagnostics block
// Assumes: short pwm step and hold unit so frames stay brief
// Notes: inputs change at falling edges only
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  localparam int STEP = 4;
  localparam int UNIT = 50;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] ev = 3'h0;
  logic pkt = 1'b0;
  logic [7:0] lvl = 8'h06;
  logic cv, cw, rv, re, fd, po, oe_n, cm, sv, strap, v, e;
  logic [7:0] cc;
  logic [15:0] cp, rd, d;
  logic [8:0] ob;
  int n_fail = 0;
  int samples_checked = 0;
  int hi;
  int n_fac = 0;
  logic [7:0] codes [9] = '{8'h0f, 8'h40, 8'h1b, 8'h22, 8'h1c, 8'h14, 8'h25, 8'h26, 8'h2c};
  logic [15:0] vals [9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0006, rld_pkg::FW_VERSION,
    rld_pkg::SERIAL_UPPER, rld_pkg::SERIAL_LOWER, {8'h00, rld_pkg::IN_BUF_SIZE}};
  logic [7:0] lvls [5] = '{8'h06, 8'h10, 8'h1a, 8'h24, 8'h36};
  int duty [5] = '{0, 19, 25, 31, 38};
  // pin pulled to the strap level whenever the device lets go
  wire logic pin = oe_n ? strap : po;
  always #5 clk_in = ~clk_in;
  // factory load pulses, counted while they stand
  always @(negedge clk_in) begin
    if (fd === 1'b1) begin
      n_fac++;
    end
  end

  rld_diag #(.STEP_CYCLES(STEP), .UNIT_CYCLES(UNIT)) u_dut (.clk_in, .reset_in,
    .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_code_in(cc), .cmd_param_in(cp),
    .rsp_valid_out(rv), .rsp_error_out(re), .rsp_data_out(rd), .factory_default_out(fd),
    .rx_abort_event_in(ev[0]), .integrity_event_in(ev[1]), .tx_drop_event_in(ev[2]),
    .packet_rx_in(pkt), .packet_level_in(lvl), .config_pin_in(pin), .config_pin_out(po),
    .config_pin_oe_n_out(oe_n), .command_mode_out(cm), .strap_valid_out(sv),
    .out_buffer_size_out(ob));
  rld_host u_host (.clk_in, .cmd_valid_out(cv), .cmd_write_out(cw), .cmd_code_out(cc),
    .cmd_param_out(cp), .rsp_valid_in(rv), .rsp_error_in(re), .rsp_data_in(rd),
    .strap_out(strap));

  // one command; data unchecked on refusals and on the factory load
  task automatic run(input logic w, input logic [7:0] c, input logic [15:0] p,
      input logic [15:0] xd, input logic xe);
    u_host.cmd(w, c, p, v, e, d);
    `CHK(v, 1'b1)
    `CHK(e, xe)
    if (!xe && c !== rld_pkg::CODE_FACTORY_LOAD) `CHK(d, xd)
  endtask
  // one packet, a settle wait, then high cycles over a whole period
  task automatic frame(input logic [7:0] l, input int settle, output int n);
    lvl = l;
    pkt = 1'b1;
    @(negedge clk_in);
    pkt = 1'b0;
    lvl = ~l;
    repeat (settle) @(negedge clk_in);
    n = 0;
    repeat (40 * STEP) begin
      @(negedge clk_in);
      n += (oe_n === 1'b0 && po === 1'b1) ? 1 : 0;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog well past the 1500 or so cycles the run needs
  initial begin
    #500000;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (6) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (20) @(negedge clk_in);
    `CHK(sv, 1'b1)
    `CHK(cm, 1'b0)
    `CHK(oe_n, 1'b1)
    `CHK(ob, 9'h0c0)
    // reset values, then refused writes leave read-only words alone
    for (int i = 0; i < 9; i++) begin
      run(1'b0, codes[i], 16'h0, vals[i], 1'b0);
      if (i > 3) begin
        run(1'b1, codes[i], 16'h5a5a, vals[i], 1'b1);
        run(1'b0, codes[i], 16'h0, vals[i], 1'b0);
      end
    end
    // counters: saturation, single steps, load beating an event
    for (int i = 0; i < 3; i++) begin
      run(1'b1, codes[i], 16'hfffd, 16'h0, 1'b0);
      ev[i] = 1'b1;
      repeat (3) @(negedge clk_in);
      ev[i] = 1'b0;
      run(1'b1, codes[i], 16'h0010, 16'hffff, 1'b0);
      ev[i] = 1'b1;
      @(negedge clk_in);
      ev[i] = 1'b0;
      run(1'b0, codes[i], 16'h0, 16'h0011, 1'b0);
      ev[i] = 1'b1;
      run(1'b1, codes[i], 16'h0005, 16'h0011, 1'b0);
      ev[i] = 1'b0;
      run(1'b0, codes[i], 16'h0, 16'h0006, 1'b0);
    end
    // factory load clears the hold setting and frees the pin
    run(1'b1, 8'h22, 16'h0003, 16'h0, 1'b0);
    run(1'b0, 8'h0e, 16'h0, 16'h0, 1'b0);
    `CHK(n_fac, 1)
    run(1'b0, 8'h22, 16'h0, 16'h0, 1'b0);
    `CHK(oe_n, 1'b1)
    // permanent hold: pin low until the first packet
    run(1'b1, 8'h22, 16'h00ff, 16'h0, 1'b0);
    repeat (3) @(negedge clk_in);
    `CHK(oe_n, 1'b0)
    `CHK(po, 1'b0)
    for (int i = 0; i < 5; i++) begin
      frame(lvls[i], 4, hi);
      `CHK(hi, duty[i] * STEP)
    end
    run(1'b0, 8'h1c, 16'h0, 16'h0036, 1'b0);
    frame(8'h10, UNIT * 3, hi);
    `CHK(hi, 19 * STEP)
    // one hold unit, then zero duty with the pin still driven
    run(1'b1, 8'h22, 16'h0001, 16'h00ff, 1'b0);
    frame(8'h24, UNIT + 4, hi);
    `CHK(hi, 0)
    `CHK(oe_n, 1'b0)
    // second reset with the strap low: command mode asked for, counts cleared
    u_host.set_strap(1'b0);
    reset_in = 1'b1;
    repeat (6) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (20) @(negedge clk_in);
    `CHK(sv, 1'b1)
    `CHK(cm, 1'b1)
    `CHK(oe_n, 1'b1)
    for (int i = 0; i < 3; i++) begin
      run(1'b0, codes[i], 16'h0, 16'h0, 1'b0);
    end
    finish_test();
  end
endmodule
`default_nettype wire
